// file: src/hwm_defs.svh
// Offsets, field positions, reset values and timing counts of the monitor register bank
`ifndef HWM_DEFS_SVH
`define HWM_DEFS_SVH

`define HWM_ADDR_CFG      7'h40
`define HWM_ADDR_STAT1    7'h41
`define HWM_ADDR_STAT2    7'h42
`define HWM_ADDR_MASK0    7'h43
`define HWM_ADDR_MASK1    7'h44
`define HWM_ADDR_MASK2    7'h45
`define HWM_ADDR_MASK3    7'h46
`define HWM_ADDR_FANDIV   7'h47
`define HWM_ADDR_SERADDR  7'h48
`define HWM_ADDR_CHIPID   7'h49
`define HWM_POST_LAST     7'h1F
`define HWM_VAL_LO_LAST   7'h3F
`define HWM_VAL_HI_FIRST  7'h60
`define HWM_VAL_HI_LAST   7'h7F

`define HWM_CFG_START     0
`define HWM_CFG_SMI_EN    1
`define HWM_CFG_IRQ_EN    2
`define HWM_CFG_INHIBIT   3
`define HWM_CFG_RESET     4
`define HWM_CFG_NMI_SEL   5
`define HWM_CFG_BYPASS    6
`define HWM_CFG_INIT      7
`define HWM_RST_PERMIT    7

`define HWM_CFG_RST       8'h08
`define HWM_STAT_RST      8'h00
`define HWM_MASK_RST      8'h00
`define HWM_MASK3_RST     8'h40
`define HWM_FANDIV_RST    4'h5
`define HWM_SERADDR_RST   8'h2D
`define HWM_INDEX_RST     7'h00

`define HWM_CLK_KHZ       25000
`define HWM_RST_PULSE_MS  20
`define HWM_RST_CNT_W     20

`endif

// file: src/hwm_pkg.sv
// Types shared by the monitor register bank
package hwm_pkg;

   typedef enum logic [0:0] {
      HWM_RST_IDLE  = 1'b0,
      HWM_RST_PULSE = 1'b1
   } hwm_rst_state_t;

   typedef logic [7:0] hwm_byte_t;
   typedef logic [6:0] hwm_index_t;

endpackage : hwm_pkg

// file: src/hwm_ram.sv
// Byte storage for self-test codes and measurement values, registered read
`timescale 1ns/1ps
module hwm_ram (
   // Clock
   input  wire logic               sys_clk_in,
   // Access
   input  wire logic               we_in,
   input  wire hwm_pkg::hwm_index_t addr_in,
   input  wire hwm_pkg::hwm_byte_t  wdata_in,
   output hwm_pkg::hwm_byte_t       rdata_out
);
   import hwm_pkg::*;

   hwm_byte_t mem_q [0:127];
   hwm_byte_t rdata_q;

   // No reset on contents; storage is undefined until written
   always_ff @(posedge sys_clk_in) begin
      if (we_in) begin
         mem_q[addr_in] <= wdata_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      rdata_q <= mem_q[addr_in];
   end

   assign rdata_out = rdata_q;

endmodule : hwm_ram

// file: src/hwm_regs.sv
// Indexed register bank of the hardware monitor with host index and data ports
`timescale 1ns/1ps
`include "hwm_defs.svh"
module hwm_regs #(
   parameter int unsigned RESET_PULSE_CYCLES = `HWM_RST_PULSE_MS * `HWM_CLK_KHZ,
   parameter logic [7:0]  CHIP_ID            = 8'hA5  // Arbitrary identity value
) (
   // Clock and reset
   input  wire logic                sys_clk_in,
   input  wire logic                srst_in,
   // Host port, synchronous to sys_clk_in
   input  wire logic                host_sel_data_in,
   input  wire logic                host_rd_in,
   input  wire logic                host_wr_in,
   input  wire hwm_pkg::hwm_byte_t  host_wdata_in,
   output hwm_pkg::hwm_byte_t       host_rdata_out,
   output logic                     host_rvalid_out,
   // Monitoring events, one-cycle pulses from the datapath
   input  wire logic                analog_input_0_in,
   input  wire logic                analog_input_1_in,
   input  wire logic                analog_input_2_in,
   input  wire logic                analog_input_3_in,
   input  wire logic                temp_limit_in,
   input  wire logic                tach_limit_1_in,
   input  wire logic                tach_limit_2_in,
   // Pins
   input  wire logic                board_temp_alarm_input_n_in,
   input  wire logic [3:0]          voltage_id_inputs_in,
   // Interrupt and control outputs
   output logic                     system_mgmt_interrupt_n_out,
   output logic                     host_irq_n_out,
   output logic                     host_irq_nmi_sel_out,
   output logic                     chip_reset_n_out,
   output logic                     bypass_pin_out,
   output logic                     bypass_pin_oe_out,
   output logic                     monitor_run_out
);
   import hwm_pkg::*;

   localparam logic [`HWM_RST_CNT_W-1:0] RST_LAST =
      `HWM_RST_CNT_W'(RESET_PULSE_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   // Locations backed by the byte storage instead of registers
   function automatic logic is_ram(input hwm_index_t idx);
      is_ram = (idx <= `HWM_VAL_LO_LAST) || (idx >= `HWM_VAL_HI_FIRST);
   endfunction : is_ram

   function automatic hwm_index_t next_index(input hwm_index_t idx);
      if (idx == `HWM_ADDR_STAT1 || idx == `HWM_ADDR_MASK0 || idx == `HWM_ADDR_MASK2) begin
         next_index = idx + 7'h01;
      end else if (idx < `HWM_POST_LAST) begin
         next_index = idx + 7'h01;
      end else if (idx >= `HWM_VAL_HI_FIRST && idx < `HWM_VAL_HI_LAST) begin
         next_index = idx + 7'h01;
      end else begin
         next_index = idx;
      end
   endfunction : next_index

   ////////////////////////////////////////////////////////////////////////////////
   // State

   hwm_index_t     index_q;
   logic           busy_q;
   hwm_byte_t      cfg_q;
   hwm_byte_t      stat1_q;
   hwm_byte_t      mask_q [0:3];
   logic [3:0]     fandiv_q;
   hwm_byte_t      seraddr_q;
   hwm_rst_state_t rst_state_q;
   logic [`HWM_RST_CNT_W-1:0] rst_cnt_q;
   logic           bti_meta_q;
   logic           bti_sync_q;
   logic [3:0]     vid_meta_q;
   logic [3:0]     vid_sync_q;
   logic           rd_pend_q;
   logic           rd_ram_q;
   hwm_byte_t      rd_reg_q;
   hwm_byte_t      rdata_q;
   logic           rvalid_q;
   logic           smi_n_q;
   logic           irq_n_q;
   logic           nmi_sel_q;
   logic           reset_n_q;
   logic           bypass_oe_q;
   logic           bypass_q;
   logic           run_q;
   hwm_byte_t      ram_rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // Access decode

   logic data_wr;
   logic data_rd;
   logic data_acc;
   logic index_wr;
   logic cfg_wr;
   logic soft_init;
   logic monitor_run;
   logic pulse_done;
   logic reset_permit;

   assign data_wr      = host_wr_in && host_sel_data_in;
   assign data_rd      = host_rd_in && host_sel_data_in;
   assign data_acc     = data_wr || data_rd;
   assign index_wr     = host_wr_in && !host_sel_data_in;
   assign cfg_wr       = data_wr && (index_q == `HWM_ADDR_CFG);
   assign soft_init    = cfg_wr && host_wdata_in[`HWM_CFG_INIT];
   assign reset_permit = mask_q[1][`HWM_RST_PERMIT];
   // Inhibit also halts monitoring, not only the two interrupt pins
   assign monitor_run  = cfg_q[`HWM_CFG_START] && !cfg_q[`HWM_CFG_INHIBIT];
   assign pulse_done   = (rst_state_q == HWM_RST_PULSE) && (rst_cnt_q == RST_LAST);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         bti_meta_q <= 1'b1;
         bti_sync_q <= 1'b1;
         vid_meta_q <= 4'h0;
         vid_sync_q <= 4'h0;
      end else begin
         bti_meta_q <= board_temp_alarm_input_n_in;
         bti_sync_q <= bti_meta_q;
         vid_meta_q <= voltage_id_inputs_in;
         vid_sync_q <= vid_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Index pointer and busy flag

   always_ff @(posedge sys_clk_in) begin
      if (srst_in || soft_init) begin
         index_q <= `HWM_INDEX_RST;
         busy_q  <= 1'b0;
      end else if (index_wr) begin
         index_q <= host_wdata_in[6:0];
         busy_q  <= 1'b1;
      end else if (data_acc) begin
         index_q <= next_index(index_q);
         busy_q  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration

   always_ff @(posedge sys_clk_in) begin
      if (srst_in || soft_init) begin
         cfg_q <= `HWM_CFG_RST;
      end else begin
         if (cfg_wr) begin
            cfg_q <= host_wdata_in;
            // Request sticks while a pulse runs; unpermitted requests are dropped
            cfg_q[`HWM_CFG_RESET] <= cfg_q[`HWM_CFG_RESET] ||
                                     (host_wdata_in[`HWM_CFG_RESET] && reset_permit);
         end
         if (pulse_done) begin
            cfg_q[`HWM_CFG_RESET] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reset pulse generator

   always_ff @(posedge sys_clk_in) begin
      if (srst_in || soft_init) begin
         rst_state_q <= HWM_RST_IDLE;
         rst_cnt_q   <= '0;
         reset_n_q   <= 1'b1;
      end else begin
         unique case (rst_state_q)
            HWM_RST_IDLE: begin
               rst_cnt_q <= '0;
               if (cfg_q[`HWM_CFG_RESET]) begin
                  rst_state_q <= HWM_RST_PULSE;
                  reset_n_q   <= 1'b0;
               end
            end
            HWM_RST_PULSE: begin
               rst_cnt_q <= rst_cnt_q + `HWM_RST_CNT_W'(1);
               if (pulse_done) begin
                  rst_state_q <= HWM_RST_IDLE;
                  reset_n_q   <= 1'b1;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // First interrupt status, sticky; read clears, a same-cycle event wins

   hwm_byte_t stat1_evt;

   always_comb begin
      stat1_evt = 8'h00;
      if (monitor_run) begin
         stat1_evt[0] = analog_input_0_in;
         stat1_evt[1] = analog_input_1_in;
         stat1_evt[2] = analog_input_2_in;
         stat1_evt[3] = analog_input_3_in;
         stat1_evt[4] = temp_limit_in;
         stat1_evt[5] = !bti_sync_q;
         stat1_evt[6] = tach_limit_1_in;
         stat1_evt[7] = tach_limit_2_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in || soft_init) begin
         stat1_q <= `HWM_STAT_RST;
      end else if (data_rd && index_q == `HWM_ADDR_STAT1) begin
         stat1_q <= stat1_evt;
      end else begin
         // Host writes are ignored; inhibit leaves content untouched
         stat1_q <= stat1_q | stat1_evt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mask registers and divisor nibble

   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_mask
         always_ff @(posedge sys_clk_in) begin
            if (srst_in || soft_init) begin
               mask_q[k] <= (k == 3) ? `HWM_MASK3_RST : `HWM_MASK_RST;
            end else if (data_wr && index_q == `HWM_ADDR_MASK0 + 7'(k)) begin
               mask_q[k] <= host_wdata_in;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_in) begin
      if (srst_in || soft_init) begin
         fandiv_q <= `HWM_FANDIV_RST;
      end else if (data_wr && index_q == `HWM_ADDR_FANDIV) begin
         fandiv_q <= host_wdata_in[7:4];
      end
   end

   // Soft initialization deliberately leaves this one alone
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         seraddr_q <= `HWM_SERADDR_RST;
      end else if (data_wr && index_q == `HWM_ADDR_SERADDR) begin
         seraddr_q <= host_wdata_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Byte storage and read path

   hwm_ram u_ram (
      .sys_clk_in (sys_clk_in),
      .we_in      (data_wr && is_ram(index_q)),
      .addr_in    (index_q),
      .wdata_in   (host_wdata_in),
      .rdata_out  (ram_rdata)
   );

   hwm_byte_t reg_value;

   always_comb begin
      reg_value = 8'h00;
      if (!host_sel_data_in) begin
         reg_value = {busy_q, index_q};
      end else begin
         unique case (index_q)
            `HWM_ADDR_CFG:            reg_value = cfg_q;
            `HWM_ADDR_STAT1:          reg_value = stat1_q;
            `HWM_ADDR_MASK0:          reg_value = mask_q[0];
            `HWM_ADDR_MASK1:          reg_value = mask_q[1];
            `HWM_ADDR_MASK2:          reg_value = mask_q[2];
            `HWM_ADDR_MASK3:          reg_value = mask_q[3];
            `HWM_ADDR_FANDIV:         reg_value = {fandiv_q, vid_sync_q};
            `HWM_ADDR_SERADDR:        reg_value = seraddr_q;
            `HWM_ADDR_CHIPID:         reg_value = CHIP_ID;
            default:                  reg_value = 8'h00;
         endcase
      end
   end

   // Two-cycle read: storage output is itself registered
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         rd_pend_q <= 1'b0;
         rd_ram_q  <= 1'b0;
         rd_reg_q  <= 8'h00;
         rdata_q   <= 8'h00;
         rvalid_q  <= 1'b0;
      end else begin
         rd_pend_q <= host_rd_in;
         if (host_rd_in) begin
            rd_ram_q <= host_sel_data_in && is_ram(index_q);
            rd_reg_q <= reg_value;
         end
         rvalid_q <= rd_pend_q;
         if (rd_pend_q) begin
            rdata_q <= rd_ram_q ? ram_rdata : rd_reg_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt and pin outputs

   logic smi_any;
   logic irq_any;

   // Status stays set when start is cleared, so the pins keep their level
   assign smi_any = |(stat1_q & ~mask_q[0]);
   assign irq_any = |(stat1_q & ~mask_q[2]);

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         smi_n_q     <= 1'b1;
         irq_n_q     <= 1'b1;
         nmi_sel_q   <= 1'b0;
         bypass_oe_q <= 1'b0;
         bypass_q    <= 1'b0;
         run_q       <= 1'b0;
      end else begin
         smi_n_q     <= !(cfg_q[`HWM_CFG_SMI_EN] && !cfg_q[`HWM_CFG_INHIBIT]
                          && smi_any);
         irq_n_q     <= !(cfg_q[`HWM_CFG_IRQ_EN] && !cfg_q[`HWM_CFG_INHIBIT]
                          && irq_any);
         nmi_sel_q   <= cfg_q[`HWM_CFG_NMI_SEL];
         bypass_oe_q <= cfg_q[`HWM_CFG_BYPASS];
         bypass_q    <= 1'b0;
         run_q       <= monitor_run;
      end
   end

   assign host_rdata_out              = rdata_q;
   assign host_rvalid_out             = rvalid_q;
   assign system_mgmt_interrupt_n_out = smi_n_q;
   assign host_irq_n_out              = irq_n_q;
   assign host_irq_nmi_sel_out        = nmi_sel_q;
   assign chip_reset_n_out            = reset_n_q;
   assign bypass_pin_out              = bypass_q;
   assign bypass_pin_oe_out           = bypass_oe_q;
   assign monitor_run_out             = run_q;

endmodule : hwm_regs

// file: verif/hwm_regs_checker.sv
// Port-level assertions for the monitor register bank
`timescale 1ns/1ps
module hwm_regs_checker #(
   parameter int unsigned RESET_PULSE_CYCLES = 16
) (
   // Clock and reset
   input  wire logic               sys_clk_in,
   input  wire logic               srst_in,
   // Host port
   input  wire logic               host_sel_data_in,
   input  wire logic               host_rd_in,
   input  wire logic               host_wr_in,
   input  wire hwm_pkg::hwm_byte_t host_wdata_in,
   input  wire hwm_pkg::hwm_byte_t host_rdata_out,
   input  wire logic               host_rvalid_out,
   // Outputs
   input  wire logic               system_mgmt_interrupt_n_out,
   input  wire logic               host_irq_n_out,
   input  wire logic               host_irq_nmi_sel_out,
   input  wire logic               chip_reset_n_out,
   input  wire logic               bypass_pin_out,
   input  wire logic               bypass_pin_oe_out,
   input  wire logic               monitor_run_out
);
   import hwm_pkg::*;
   // Index 40h is never reached by stepping, so a flag is enough to shadow it
   logic        at_cfg_q;
   logic        busy_q;
   hwm_byte_t   cfg_q;
   logic [31:0] low_cnt_q;
   wire logic   idx_wr  = host_wr_in && !host_sel_data_in;
   wire logic   dat_acc = (host_rd_in || host_wr_in) && host_sel_data_in;
   wire logic   cfg_wr  = host_wr_in && host_sel_data_in && at_cfg_q;
   wire logic   run_exp = cfg_q[0] && !cfg_q[3];
   wire logic   nmi_exp = cfg_q[5];
   wire logic   byp_exp = cfg_q[6];
   wire logic   smi_off = !cfg_q[1] || cfg_q[3];
   wire logic   irq_off = !cfg_q[2] || cfg_q[3];
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_in) begin
      if (srst_in || (cfg_wr && host_wdata_in[7])) at_cfg_q <= 1'b0;
      else if (idx_wr) at_cfg_q <= (host_wdata_in[6:0] == 7'h40);
   end
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) cfg_q <= 8'h08;
      else if (cfg_wr) cfg_q <= host_wdata_in[7] ? 8'h08 : (host_wdata_in & 8'h6F);
   end
   always_ff @(posedge sys_clk_in) begin
      if (srst_in || dat_acc) busy_q <= 1'b0;
      else if (idx_wr) busy_q <= 1'b1;
   end
   always_ff @(posedge sys_clk_in) begin
      if (srst_in || chip_reset_n_out) low_cnt_q <= 32'h0;
      else low_cnt_q <= low_cnt_q + 32'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   rvalid_lat_a: assert property (host_rd_in |-> ##2 host_rvalid_out)
      else $error("read answer late or missing");
   rvalid_src_a: assert property (host_rvalid_out |-> $past(host_rd_in, 2))
      else $error("read answer without a read");
   busy_flag_a: assert property (host_rd_in && !host_sel_data_in
      |-> ##2 host_rdata_out[7] == $past(busy_q, 2))
      else $error("busy flag wrong");
   pulse_len_a: assert property ($rose(chip_reset_n_out)
      |-> low_cnt_q == RESET_PULSE_CYCLES)
      else $error("reset pulse length wrong");
   run_state_a: assert property (monitor_run_out == $past(run_exp))
      else $error("monitor run state wrong");
   nmi_route_a: assert property (host_irq_nmi_sel_out == $past(nmi_exp))
      else $error("interrupt route wrong");
   bypass_drive_a: assert property (bypass_pin_oe_out == $past(byp_exp) && !bypass_pin_out)
      else $error("bypass pin drive wrong");
   smi_gate_a: assert property ($past(smi_off) |-> system_mgmt_interrupt_n_out)
      else $error("system interrupt not gated");
   irq_gate_a: assert property ($past(irq_off) |-> host_irq_n_out)
      else $error("host interrupt not gated");
   cover property ($rose(chip_reset_n_out));
   cover property ($fell(system_mgmt_interrupt_n_out));
   cover property (idx_wr ##2 host_rd_in && !host_sel_data_in);
endmodule : hwm_regs_checker

// file: verif/hwm_host_model.sv
// Host bus model for the index and data ports
`timescale 1ns/1ps
module hwm_host_model (
   // Clock
   input  wire logic               sys_clk_in,
   // Answer
   input  wire hwm_pkg::hwm_byte_t rdata_in,
   input  wire logic               rvalid_in,
   // Requests
   output logic                    sel_data_out,
   output logic                    rd_out,
   output logic                    wr_out,
   output hwm_pkg::hwm_byte_t      wdata_out
);
   import hwm_pkg::*;
   initial begin
      sel_data_out = 1'b0;
      rd_out = 1'b0;
      wr_out = 1'b0;
      wdata_out = 8'h00;
   end
   // One strobe per call; released data shows the inverse, never the old byte
   task automatic acc(input logic sel, input logic wr, input hwm_byte_t d,
                      output hwm_byte_t q);
      int n;
      @(posedge sys_clk_in);
      #1;
      sel_data_out = sel;
      rd_out = !wr;
      wr_out = wr;
      wdata_out = d;
      @(posedge sys_clk_in);
      #1;
      rd_out = 1'b0;
      wr_out = 1'b0;
      wdata_out = ~d;
      for (n = 0; !wr && n < 4 && rvalid_in !== 1'b1; n++) begin
         @(posedge sys_clk_in);
         #1;
      end
      q = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
   endtask : acc
endmodule : hwm_host_model

// file: verif/hwm_regs_tb.sv
// Self-checking bench for the monitor register bank
`timescale 1ns/1ps
module hwm_regs_tb;
   import hwm_pkg::*;
   localparam hwm_byte_t ID = 8'h3C;  // Arbitrary identity value
   logic      sys_clk_in, srst_in, host_sel_data_in, host_rd_in, host_wr_in;
   logic      host_rvalid_out, system_mgmt_interrupt_n_out, host_irq_n_out;
   logic      host_irq_nmi_sel_out, chip_reset_n_out, bypass_pin_out;
   logic      bypass_pin_oe_out, monitor_run_out;
   hwm_byte_t host_wdata_in, host_rdata_out, ev;
   logic [3:0] vid;
   int        error_cnt = 0;
   int        checks = 0;
   // Pin snapshot: smi_n irq_n run nmi reset_n oe bypass 0
   wire hwm_byte_t pins = {system_mgmt_interrupt_n_out, host_irq_n_out, monitor_run_out,
      host_irq_nmi_sel_out, chip_reset_n_out, bypass_pin_oe_out, bypass_pin_out, 1'b0};
   // Ops are {data port, write, byte}; reads carry the expected byte
   logic [9:0] rows [$] = '{
      10'h140, 10'h208, 10'h040, 10'h143, 10'h0C3, 10'h3A5, 10'h044, 10'h380, 10'h044,
      10'h145, 10'h200, 10'h240, 10'h046, 10'h143, 10'h2A5, 10'h280,
      10'h11E, 10'h311, 10'h322, 10'h01F, 10'h333, 10'h11E, 10'h211, 10'h233, 10'h01F,
      10'h17E, 10'h344, 10'h355, 10'h07F, 10'h17E, 10'h244, 10'h255, 10'h07F,
      10'h141, 10'h200, 10'h042, 10'h200, 10'h042, 10'h148, 10'h22D, 10'h147, 10'h25A,
      10'h149, 10'h300, 10'h23C, 10'h150, 10'h377, 10'h200};
   hwm_regs #(.RESET_PULSE_CYCLES(16), .CHIP_ID(ID)) DUT (
      .sys_clk_in, .srst_in, .host_sel_data_in, .host_rd_in, .host_wr_in,
      .host_wdata_in, .host_rdata_out, .host_rvalid_out,
      .analog_input_0_in(ev[0]), .analog_input_1_in(ev[1]), .analog_input_2_in(ev[2]),
      .analog_input_3_in(ev[3]), .temp_limit_in(ev[4]), .tach_limit_1_in(ev[6]),
      .tach_limit_2_in(ev[7]), .board_temp_alarm_input_n_in(!ev[5]),
      .voltage_id_inputs_in(vid), .system_mgmt_interrupt_n_out, .host_irq_n_out,
      .host_irq_nmi_sel_out, .chip_reset_n_out, .bypass_pin_out, .bypass_pin_oe_out,
      .monitor_run_out);
   hwm_host_model host (.sys_clk_in, .rdata_in(host_rdata_out), .rvalid_in(host_rvalid_out),
      .sel_data_out(host_sel_data_in), .rd_out(host_rd_in), .wr_out(host_wr_in),
      .wdata_out(host_wdata_in));
   always #20 sys_clk_in = ~sys_clk_in;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input hwm_byte_t seen, input hwm_byte_t exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic xfer(input logic [9:0] op);
      hwm_byte_t q;
      host.acc(op[9], op[8], op[7:0], q);
      if (!op[8]) chk(q, op[7:0]);
   endtask : xfer
   task automatic wreg(input hwm_byte_t a, input hwm_byte_t d);
      xfer({2'b01, a});
      xfer({2'b11, d});
   endtask : wreg
   task automatic rreg(input hwm_byte_t a, input hwm_byte_t e);
      xfer({2'b01, a});
      xfer({2'b10, e});
   endtask : rreg
   task automatic pin(input hwm_byte_t e);
      repeat (3) @(posedge sys_clk_in);
      #1;
      chk(pins, e);
   endtask : pin
   task automatic pulse_ev(input hwm_byte_t e);
      ev = e;
      repeat (3) @(posedge sys_clk_in);
      #1;
      ev = 8'h00;
   endtask : pulse_ev
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #800000;
      error_cnt++;
      complete_run();
   end
   initial begin
      int n;
      sys_clk_in = 1'b0;
      srst_in = 1'b1;
      ev = 8'h00;
      vid = 4'hA;
      repeat (4) @(posedge sys_clk_in);
      #1;
      srst_in = 1'b0;
      pin(8'hC8);
      foreach (rows[i]) xfer(rows[i]);
      // Permitted reset pulse, bit clears when it ends
      wreg(8'h40, 8'h10);
      for (n = 0; n < 8 && chip_reset_n_out !== 1'b0; n++) begin
         @(posedge sys_clk_in);
         #1;
      end
      for (n = 0; n < 64 && chip_reset_n_out === 1'b0; n++) begin
         @(posedge sys_clk_in);
         #1;
      end
      chk(8'(n), 8'h10);
      rreg(8'h40, 8'h00);
      wreg(8'h44, 8'h00);
      wreg(8'h40, 8'h10);
      rreg(8'h40, 8'h00);
      pin(8'hC8);
      // Every status source raises both outputs and clears on read
      wreg(8'h43, 8'h00);
      wreg(8'h40, 8'h27);
      pin(8'hF8);
      for (int i = 0; i < 8; i++) begin
         pulse_ev(8'h01 << i);
         pin(8'h38);
         rreg(8'h41, 8'h01 << i);
         pin(8'hF8);
      end
      wreg(8'h43, 8'hFF);
      pulse_ev(8'h01);
      pin(8'hB8);
      wreg(8'h43, 8'h00);
      pin(8'h38);
      wreg(8'h45, 8'h01);
      pin(8'h78);
      wreg(8'h45, 8'h00);
      wreg(8'h40, 8'h25);
      pin(8'hB8);
      wreg(8'h40, 8'h03);
      pin(8'h68);
      wreg(8'h40, 8'h0F);
      pin(8'hC8);
      pulse_ev(8'h02);
      wreg(8'h40, 8'h07);
      pin(8'h28);
      rreg(8'h41, 8'h01);
      pin(8'hE8);
      pulse_ev(8'h80);
      pin(8'h28);
      wreg(8'h40, 8'h06);
      pin(8'h08);
      pulse_ev(8'h04);
      rreg(8'h41, 8'h80);
      wreg(8'h40, 8'h40);
      pin(8'hCC);
      // Soft initialization keeps only the serial address among the registers
      wreg(8'h48, 8'h5A);
      wreg(8'h43, 8'hA5);
      wreg(8'h46, 8'h00);
      wreg(8'h47, 8'h3F);
      rreg(8'h47, 8'h3A);
      wreg(8'h40, 8'hC1);
      xfer(10'h000);
      rreg(8'h40, 8'h08);
      rreg(8'h43, 8'h00);
      rreg(8'h46, 8'h40);
      rreg(8'h47, 8'h5A);
      rreg(8'h48, 8'h5A);
      pin(8'hC8);
      // Reset in mid-run restores the registers, the serial address too, which alone is read back
      srst_in = 1'b1;
      repeat (4) @(posedge sys_clk_in);
      #1;
      srst_in = 1'b0;
      rreg(8'h48, 8'h2D);
      pin(8'hC8);
      complete_run();
   end
endmodule : hwm_regs_tb

bind hwm_regs hwm_regs_checker #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) chk_i (
   .sys_clk_in, .srst_in, .host_sel_data_in, .host_rd_in, .host_wr_in, .host_wdata_in,
   .host_rdata_out, .host_rvalid_out, .system_mgmt_interrupt_n_out, .host_irq_n_out,
   .host_irq_nmi_sel_out, .chip_reset_n_out, .bypass_pin_out, .bypass_pin_oe_out,
   .monitor_run_out);
